// file: hw/timer_channel_mode_control.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
`include "timer_channel_defs.svh"

// Contract
// - Edge bits 00 leave pin to port; mode-A 0 presets high, 1 low.
// - Capture mode, edge bits 01: capture on rising pin edges only.
// - Capture mode, edge bits 10: capture on falling pin edges only.
// - Capture mode, edge bits 11: capture on either pin edge.
// - Compare or buffered mode, edge bits 01: toggle output on match.
// - Compare or buffered mode, edge bits 10: drive output low on match.
// - Compare or buffered mode, edge bits 11: drive output high on match.
// - Compare with overflow-toggle set toggles output on each counter overflow.
// - Overflow-toggle bit has no effect in capture mode.
// - Reset clears the overflow-toggle bit.
// - With overflow-toggle set, overflow beats a coincident compare match.
// - Overflow-toggle clear and full-duty set force output to full duty.
// - Full-duty changes take effect only from the next period.
// - Value register holds capture or compare value; reset content undefined.
// - Capture mode: high byte read blocks captures until low byte read.
// - Compare mode: high byte write blocks matches until low byte written.
// - Event flag sets on active capture edge or counter match in compare.
module timer_channel_mode_control
  import timer_channel_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Timer pin
  input wire logic timer_pin_i,
  output logic timer_pin_o,
  output logic timer_pin_oe_o,
  // Interrupt
  output logic irq_o
);

  // ****************************************
  // Helpers
  // ****************************************

  function automatic chan_mode_e mode_of(input logic msb, input logic msa,
                                         input logic elsb, input logic elsa);
    chan_mode_e m;
    m = MODE_COMPARE;
    if ({elsb, elsa} == `ELS_PORT) begin
      m = MODE_PORT;
    end else if (!msb && !msa) begin
      m = MODE_CAPTURE;
    end
    return m;
  endfunction : mode_of

  function automatic logic [7:0] index_of(input logic [31:0] addr);
    return addr[9:2];
  endfunction : index_of

  // Capture edge selection; the port code never captures.
  function automatic logic edge_hit(input logic [1:0] sel, input logic up,
                                    input logic down);
    logic hit;
    hit = 1'b0;
    case (sel)
      `ELS_RISE_TOGGLE: begin
        hit = up;
      end
      `ELS_FALL_CLEAR: begin
        hit = down;
      end
      `ELS_BOTH_SET: begin
        hit = up || down;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : edge_hit

  // Level the pin takes on a compare match.
  function automatic logic match_level(input logic [1:0] sel, input logic cur);
    logic level;
    level = cur;
    case (sel)
      `ELS_RISE_TOGGLE: begin
        level = !cur;
      end
      `ELS_FALL_CLEAR: begin
        level = 1'b0;
      end
      `ELS_BOTH_SET: begin
        level = 1'b1;
      end
      default: begin
        level = cur;
      end
    endcase
    return level;
  endfunction : match_level

  // ****************************************
  // State
  // ****************************************

  chan_state_s st;
  chan_state_s nx;
  chan_mode_e mode;
  logic [1:0] els;
  logic addr_ok;
  logic rd_req;
  logic [7:0] rd_idx;
  logic overflow;
  logic rise;
  logic fall;
  logic active_edge;
  logic do_capture;
  logic match;
  logic event_now;
  logic flag_clear;
  logic [7:0] ctrl_read;
  logic [7:0] wbyte;

  assign mode = mode_of(st.buffered_mode_select, st.mode_select_low,
                        st.edge_level_upper, st.edge_level_lower);
  assign els = {st.edge_level_upper, st.edge_level_lower};
  assign addr_ok = hsel_i && hready_i && (htrans_i == `HTRANS_NONSEQ);
  assign rd_req = addr_ok && !hwrite_i;
  assign rd_idx = index_of(haddr_i);
  assign wbyte = hwdata_i[7:0];
  assign ctrl_read = {st.channel_event_flag, 1'b0, st.buffered_mode_select,
                      st.mode_select_low, st.edge_level_upper,
                      st.edge_level_lower, st.overflow_toggle_enable,
                      st.full_duty_force};

  // ****************************************
  // Channel events
  // ****************************************

  always_comb begin
    overflow = (st.counter == st.modulus);
    rise = st.pin_sync && !st.pin_prev;
    fall = !st.pin_sync && st.pin_prev;
    active_edge = edge_hit(els, rise, fall);
    // A half-read value pair must not be torn by a new capture.
    do_capture = (mode == MODE_CAPTURE) && active_edge && !st.capture_block;
    match = (mode == MODE_COMPARE) && (st.counter == st.value)
            && !st.compare_block;
    event_now = do_capture || match;
  end

  // ****************************************
  // Next state
  // ****************************************

  always_comb begin
    nx = st;
    flag_clear = 1'b0;

    // ****************************************
    // Pin synchroniser and edge history.
    // ****************************************
    nx.pin_meta = timer_pin_i;
    nx.pin_sync = st.pin_meta;
    nx.pin_prev = st.pin_sync;

    // ****************************************
    // Free-running counter wrapping at the modulus.
    // ****************************************
    // A modulus written below the running count lets it run on to the top first.
    if (overflow) begin
      nx.counter = 16'h0000;
    end else begin
      nx.counter = st.counter + 16'h0001;
    end

    // ****************************************
    // Capture path.
    // ****************************************
    if (do_capture) begin
      nx.value = st.counter;
    end

    // ****************************************
    // Output level.
    // ****************************************
    case (mode)
      MODE_PORT: begin
        nx.out_level = !st.mode_select_low;
      end
      MODE_COMPARE: begin
        if (st.overflow_toggle_enable && overflow) begin
          nx.out_level = !st.out_level;
        end else if (!st.overflow_toggle_enable && st.max_active) begin
          nx.out_level = 1'b1;
        end else if (match) begin
          nx.out_level = match_level(els, st.out_level);
        end
      end
      default: begin
        // Capture ignores the overflow-toggle bit entirely.
        nx.out_level = st.out_level;
      end
    endcase

    // ****************************************
    // Full duty is sampled only at the period boundary.
    // ****************************************
    if (overflow) begin
      nx.max_active = st.full_duty_force;
    end

    // ****************************************
    // Address phase: read data and read side effects.
    // ****************************************
    nx.wr_pend = addr_ok && hwrite_i;
    nx.wr_idx = rd_idx;
    nx.rdata = `RST_WORD;
    if (rd_req) begin
      case (rd_idx)
        `IDX_CTRL: begin
          nx.rdata = {24'h000000, ctrl_read};
          nx.flag_armed = st.channel_event_flag;
        end
        `IDX_VALH: begin
          nx.rdata = {24'h000000, st.value[15:8]};
          if (mode == MODE_CAPTURE) begin
            nx.capture_block = 1'b1;
          end
        end
        `IDX_VALL: begin
          nx.rdata = {24'h000000, st.value[7:0]};
          nx.capture_block = 1'b0;
        end
        `IDX_INT_STS: begin
          nx.rdata = {30'h00000000, st.int_status};
        end
        `IDX_INT_MSK: begin
          nx.rdata = {30'h00000000, st.int_mask};
        end
        `IDX_MODULUS: begin
          nx.rdata = {16'h0000, st.modulus};
        end
        `IDX_COUNTER: begin
          nx.rdata = {16'h0000, st.counter};
        end
        default: begin
          nx.rdata = `RST_WORD;
        end
      endcase
    end

    // ****************************************
    // Data phase: writes.
    // ****************************************
    if (st.wr_pend) begin
      case (st.wr_idx)
        `IDX_CTRL: begin
          nx.buffered_mode_select = wbyte[`CTL_MSB];
          nx.mode_select_low = wbyte[`CTL_MSA];
          nx.edge_level_upper = wbyte[`CTL_ELSB];
          nx.edge_level_lower = wbyte[`CTL_ELSA];
          nx.overflow_toggle_enable = wbyte[`CTL_TOV];
          nx.full_duty_force = wbyte[`CTL_MAX];
          // Only a clear after a read that saw the flag counts, so no event is lost.
          flag_clear = st.flag_armed && !wbyte[`CTL_FLAG];
          nx.flag_armed = 1'b0;
        end
        `IDX_VALH: begin
          // Holding the high byte keeps a half-written compare value from matching.
          nx.high_hold = wbyte;
          if (mode != MODE_CAPTURE) begin
            nx.compare_block = 1'b1;
          end else begin
            nx.value = {wbyte, st.value[7:0]};
          end
        end
        `IDX_VALL: begin
          if (st.compare_block) begin
            nx.value = {st.high_hold, wbyte};
          end else begin
            nx.value = {st.value[15:8], wbyte};
          end
          nx.compare_block = 1'b0;
        end
        `IDX_INT_STS: begin
          nx.int_status = st.int_status & ~hwdata_i[1:0];
        end
        `IDX_INT_MSK: begin
          nx.int_mask = hwdata_i[1:0];
        end
        `IDX_MODULUS: begin
          nx.modulus = hwdata_i[15:0];
        end
        default: begin
          nx.int_mask = st.int_mask;
        end
      endcase
    end

    // ****************************************
    // Event flag: a new event always beats a clear in the same cycle.
    // ****************************************
    if (event_now) begin
      nx.channel_event_flag = 1'b1;
      nx.flag_armed = 1'b0;
    end else if (flag_clear) begin
      nx.channel_event_flag = 1'b0;
    end

    // ****************************************
    // Sticky interrupt status, set wins over the write-one clear.
    // ****************************************
    if (event_now) begin
      nx.int_status[`INT_CHAN] = 1'b1;
    end
    if (overflow) begin
      nx.int_status[`INT_OVF] = 1'b1;
    end
    nx.irq = |(nx.int_status & nx.int_mask);

    // ****************************************
    // Pin drive.
    // ****************************************
    // In capture the pin is an input, so only a compare channel may drive it.
    nx.pin_oe = (mode_of(nx.buffered_mode_select, nx.mode_select_low,
                         nx.edge_level_upper, nx.edge_level_lower)
                 == MODE_COMPARE);
  end

  // ****************************************
  // Registers
  // ****************************************

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.modulus <= `RST_MODULUS;
      // The pin idles high, the preset level for mode_select_low at 0.
      st.out_level <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // The slave never inserts wait states, so these two are constant flops.
  logic ready_q;
  logic resp_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_q <= 1'b1;
      resp_q <= `HRESP_OKAY;
    end else begin
      ready_q <= 1'b1;
      resp_q <= `HRESP_OKAY;
    end
  end

  assign hreadyout_o = ready_q;
  assign hresp_o = resp_q;
  assign hrdata_o = st.rdata;
  assign timer_pin_o = st.out_level;
  assign timer_pin_oe_o = st.pin_oe;
  assign irq_o = st.irq;

endmodule : timer_channel_mode_control

// file: hw/timer_channel_defs.svh
`ifndef TIMER_CHANNEL_DEFS_SVH
`define TIMER_CHANNEL_DEFS_SVH

// ****************************************
// Register indices, byte address is four times the index
// ****************************************
`define IDX_CTRL 8'h26
`define IDX_VALH 8'h27
`define IDX_VALL 8'h28
`define IDX_INT_STS 8'h30
`define IDX_INT_MSK 8'h31
`define IDX_MODULUS 8'h32
`define IDX_COUNTER 8'h33

// ****************************************
// Control register fields
// ****************************************
`define CTL_FLAG 7
`define CTL_MSB 5
`define CTL_MSA 4
`define CTL_ELSB 3
`define CTL_ELSA 2
`define CTL_TOV 1
`define CTL_MAX 0

// ****************************************
// Interrupt status fields
// ****************************************
`define INT_CHAN 0
`define INT_OVF 1

// ****************************************
// Reset values and constants
// ****************************************
`define RST_MODULUS 16'hFFFF
`define RST_WORD 32'h0000_0000
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'h0
`define ELS_PORT 2'h0
`define ELS_RISE_TOGGLE 2'h1
`define ELS_FALL_CLEAR 2'h2
`define ELS_BOTH_SET 2'h3

`endif

// file: hw/timer_channel_pkg.sv
package timer_channel_pkg;

  typedef enum logic [1:0] {
    MODE_PORT = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_COMPARE = 2'b10
  } chan_mode_e;

  typedef struct packed {
    logic buffered_mode_select;
    logic mode_select_low;
    logic edge_level_upper;
    logic edge_level_lower;
    logic overflow_toggle_enable;
    logic full_duty_force;
    logic channel_event_flag;
    logic flag_armed;
    logic [15:0] value;
    logic [7:0] high_hold;
    logic capture_block;
    logic compare_block;
    logic [15:0] counter;
    logic [15:0] modulus;
    logic max_active;
    logic out_level;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic irq;
    logic pin_oe;
  } chan_state_s;

endpackage : timer_channel_pkg

// file: tb/timer_pin_model.sv
`timescale 1ns/1ns
// ****************************************
// Capture pin source
// ****************************************
module timer_pin_model (
  // Clock and command
  input wire logic clk_i,
  input wire logic lvl_i,
  // Pin
  output logic pin_o
);
  logic lvl_q = 1'b0;
  // Level moves only at a clock edge, then holds until lvl_i changes.
  always @(posedge clk_i) begin
    lvl_q <= lvl_i;
  end
  assign pin_o = lvl_q;
endmodule : timer_pin_model

// file: tb/timer_channel_mode_control_assertions.sv
`timescale 1ns/1ns
`include "timer_channel_defs.svh"
// ****************************************
// Port checker
// ****************************************
module timer_channel_mode_control_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Pin and interrupt
  input wire logic timer_pin_o,
  input wire logic timer_pin_oe_o,
  input wire logic irq_o
);
  logic wp;
  logic [7:0] wi;
  logic [5:0] ctl;
  logic [5:0] pc;
  logic [15:0] md;
  logic [15:0] cnt;
  logic st;
  logic cmp;
  logic ovf;
  // Shadow of control and modulus rebuilt from bus writes, with a free-running counter beside them.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp <= 1'b0;
      wi <= 8'h00;
      ctl <= 6'h00;
      pc <= 6'h00;
      md <= `RST_MODULUS;
      cnt <= 16'h0000;
    end else begin
      wp <= hsel_i && hready_i && htrans_i == `HTRANS_NONSEQ && hwrite_i;
      wi <= haddr_i[9:2];
      pc <= ctl;
      if (wp && wi == `IDX_CTRL) ctl <= hwdata_i[5:0];
      if (wp && wi == `IDX_MODULUS) md <= hwdata_i[15:0];
      cnt <= (cnt == md) ? 16'h0000 : cnt + 16'h0001;
    end
  end
  assign st = ctl == pc;
  assign cmp = (ctl[5] | ctl[4]) && ctl[3:2] != 2'h0;
  assign ovf = cnt == md;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_BUS_OK: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  AST_PORT_OE: assert property (st && ctl[3:2] == 2'h0 |-> !timer_pin_oe_o)
    else $error("pin driven in port mode");
  AST_PORT_LVL: assert property (st && ctl[3:2] == 2'h0 |-> timer_pin_o == !ctl[4])
    else $error("wrong preset level");
  AST_OE_ON: assert property (st && cmp |-> timer_pin_oe_o)
    else $error("compare pin not driven");
  AST_CAP_OE: assert property (st && ctl[5:4] == 2'h0 && ctl[3:2] != 2'h0 |->
    !timer_pin_oe_o)
    else $error("pin driven in capture mode");
  AST_SET_HI: assert property (st && cmp && ctl[3:0] == 4'hC |-> !$fell(timer_pin_o))
    else $error("output fell in set mode");
  AST_CLR_LO: assert property (st && cmp && ctl[3:0] == 4'h8 |-> !$rose(timer_pin_o))
    else $error("output rose in clear mode");
  AST_CAP_STILL: assert property (st && ctl[5:4] == 2'h0 && ctl[3:2] != 2'h0 |->
    $stable(timer_pin_o))
    else $error("output moved in capture mode");
  AST_OVF_TOG: assert property (st && cmp && ctl[1] && ovf |=> ##[0:1] $changed(timer_pin_o))
    else $error("no toggle on overflow");
  AST_FULL: assert property (st && cmp && ctl[1:0] == 2'h1 && ovf |-> ##2 timer_pin_o [*8])
    else $error("full duty not held");
  cover property (cmp && ovf);
  cover property (st && ctl[4] && ctl[3:2] == 2'h0);
  cover property ($rose(irq_o));
endmodule : timer_channel_mode_control_chk

bind timer_channel_mode_control timer_channel_mode_control_chk u_chk (.*);

// file: tb/timer_channel_mode_control_tb.sv
`timescale 1ns/1ns
`include "timer_channel_defs.svh"
// ****************************************
// Bench
// ****************************************
module timer_channel_mode_control_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic lvl = 1'b0;
  logic pin;
  logic pin_o;
  logic oe;
  logic irq;
  logic [31:0] rd;
  logic [31:0] v;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] cfg [8] = '{8'h18, 8'h14, 8'h1C, 8'h1E, 8'h0E, 8'h2C, 8'h19, 8'h18};
  logic [1:0] ex [8] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
  always #25 clk = ~clk;
  timer_pin_model pm (.clk_i(clk), .lvl_i(lvl), .pin_o(pin));
  timer_channel_mode_control dut (.clk_i(clk), .nrst_i(nrst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .timer_pin_i(pin), .timer_pin_o(pin_o), .timer_pin_oe_o(oe),
    .irq_o(irq));
  task end_sim;
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // The address phase is held until hready is seen high, then the data phase.
  task bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'h0};
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, `IDX_CTRL, 32'h0); chk("ctrl", 32'h0, rd);
    bus(1'b0, `IDX_MODULUS, 32'h0); chk("modulus", {16'h0, `RST_MODULUS}, rd);
    bus(1'b1, `IDX_MODULUS, 32'h1F);
    bus(1'b0, 8'h40, 32'h0); chk("unmapped", 32'h0, rd);
    bus(1'b1, `IDX_CTRL, 32'h10); repeat (2) @(posedge clk);
    chk("port low", 32'h0, {oe, pin_o});
    bus(1'b1, `IDX_CTRL, 32'h0); repeat (2) @(posedge clk);
    chk("port high", 32'h1, {oe, pin_o});
    bus(1'b1, `IDX_INT_MSK, 32'h1);
    for (int e = 1; e < 4; e++) begin
      bus(1'b1, `IDX_CTRL, 32'(e << 2));
      bus(1'b1, `IDX_INT_STS, 32'h3);
      for (int f = 0; f < 2; f++) begin
        lvl <= !f;
        repeat (8) @(posedge clk);
        chk("irq", 32'((e >> f) & 1), irq);
        bus(1'b0, `IDX_INT_STS, 32'h0); chk("event", 32'((e >> f) & 1), rd[0]);
        bus(1'b1, `IDX_INT_STS, 32'h1);
      end
    end
    bus(1'b1, `IDX_INT_MSK, 32'h0);
    lvl <= 1'b1;
    repeat (8) @(posedge clk);
    chk("masked irq", 32'h0, irq);
    bus(1'b0, `IDX_INT_STS, 32'h0); chk("sticky", 32'h1, rd[0]);
    bus(1'b1, `IDX_INT_STS, 32'h1);
    bus(1'b0, `IDX_INT_STS, 32'h0); chk("cleared", 32'h0, rd[0]);
    bus(1'b0, `IDX_VALL, 32'h0); v = rd;
    bus(1'b0, `IDX_VALH, 32'h0);
    lvl <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, `IDX_VALL, 32'h0); chk("blocked", v, rd);
    lvl <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, `IDX_VALL, 32'h0); chk("captured", 32'h1, 32'(rd !== v));
    bus(1'b1, `IDX_VALH, 32'h0);
    bus(1'b1, `IDX_VALL, 32'h10);
    // Each mode runs over two full periods of 32 counts before the level is judged.
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `IDX_CTRL, {24'h0, cfg[k]});
      if (k == 7) begin
        @(posedge clk);
        chk("duty hold", 32'h1, pin_o);
      end
      repeat (80) @(posedge clk);
      v = {31'h0, pin_o};
      if (ex[k] < 2'h2) chk("level", {30'h0, ex[k]}, pin_o);
      if (cfg[k] == 8'h14) begin
        repeat (32) @(posedge clk);
        chk("toggle", {31'h0, ~v[0]}, pin_o);
      end
    end
    bus(1'b1, `IDX_VALH, 32'h0);
    bus(1'b1, `IDX_INT_STS, 32'h3);
    repeat (40) @(posedge clk);
    bus(1'b0, `IDX_INT_STS, 32'h0); chk("match blocked", 32'h0, rd[0]);
    bus(1'b1, `IDX_VALL, 32'h10);
    repeat (40) @(posedge clk);
    bus(1'b0, `IDX_INT_STS, 32'h0); chk("match flag", 32'h1, rd[0]);
    end_sim();
  end
endmodule : timer_channel_mode_control_tb
